/* parallel_io_ports.sv */
// Parallel I/O ports with a classic Wishbone register slave
`timescale 1ns/1ps
module parallel_io_ports (
   input  wire logic                      sys_clk_i,
   input  wire logic                      reset_n_i,
   input  parallel_io_pkg::wb_req_s       wb_req_i,
   output parallel_io_pkg::wb_rsp_s       wb_rsp_o,
   input  wire logic [7:0]                port_a_pin_i,
   output logic      [7:0]                port_a_pin_o,
   output logic      [7:0]                port_a_pin_oe_o,
   input  wire logic [7:0]                port_b_pin_i,
   output logic      [7:0]                port_b_pin_o,
   output logic      [7:0]                port_b_pin_oe_o,
   output logic      [7:0]                port_b_pullup_o,
   input  wire logic [7:0]                port_c_pin_i,
   output logic      [7:0]                port_c_pin_o,
   output logic      [7:0]                port_c_pin_oe_o,
   input  wire logic [6:0]                port_d_pin_i,
   output logic      [6:0]                port_d_pin_o,
   output logic      [6:0]                port_d_pin_oe_o,
   input  wire logic [6:0]                serial_pin_enable_i,
   input  wire logic [6:0]                serial_pin_data_i,
   input  wire logic [6:0]                serial_pin_oe_i,
   input  wire logic                      irq_edge_and_level_i,
   input  wire logic [7:0]                port_b_option_register_i,
   input  wire logic                      full_feature_configuration_i,
   output logic                           port_b_irq_request_o
);

   import parallel_io_pkg::*;

   io_state_s         r;
   io_state_s         next_r;

   logic [13:0]       reg_idx;
   logic              access;
   logic              wr_lane0;

   logic [7:0]        read_a;
   logic [7:0]        read_b;
   logic [7:0]        read_c;
   logic [6:0]        read_d_bank;
   logic [6:0]        read_d;
   logic [6:0]        dir_d_effective;
   logic [6:0]        bank_d_pin_o;
   logic [6:0]        bank_d_pin_oe;
   logic [6:0]        serial_oe_gated;

   logic [7:0]        irq_enabled;
   logic              irq_line;
   logic              irq_level_active;

   // Bus decode
   assign reg_idx  = wb_req_i.adr[15:2];
   assign access   = wb_req_i.cyc & wb_req_i.stb & ~r.ack;
   assign wr_lane0 = access & wb_req_i.we & wb_req_i.sel[0];

   port_bank #(
      .WIDTH (PORT_WIDTH)
   ) u_port_a (
      .data_i   (r.data_a),
      .dir_i    (r.dir_a),
      .pin_i    (port_a_pin_i),
      .pin_o    (port_a_pin_o),
      .pin_oe_o (port_a_pin_oe_o),
      .read_o   (read_a)
   );

   port_bank #(
      .WIDTH (PORT_WIDTH)
   ) u_port_b (
      .data_i   (r.data_b),
      .dir_i    (r.dir_b),
      .pin_i    (port_b_pin_i),
      .pin_o    (port_b_pin_o),
      .pin_oe_o (port_b_pin_oe_o),
      .read_o   (read_b)
   );

   // port C; its top pin is the strong-drive pad, a pad property only
   port_bank #(
      .WIDTH (PORT_WIDTH)
   ) u_port_c (
      .data_i   (r.data_c),
      .dir_i    (r.dir_c),
      .pin_i    (port_c_pin_i),
      .pin_o    (port_c_pin_o),
      .pin_oe_o (port_c_pin_oe_o),
      .read_o   (read_c)
   );

   // direction honoured only in full-feature configuration
   assign dir_d_effective = r.dir_d & {PORT_D_WIDTH{r.full_feature}};

   // port D, input-only when compatibility configuration
   port_bank #(
      .WIDTH (PORT_D_WIDTH)
   ) u_port_d (
      .data_i   (r.data_d),
      .dir_i    (dir_d_effective),
      .pin_i    (port_d_pin_i),
      .pin_o    (bank_d_pin_o),
      .pin_oe_o (bank_d_pin_oe),
      .read_o   (read_d_bank)
   );

   // serial drivers are held off while reset is low
   assign serial_oe_gated = serial_pin_oe_i & {PORT_D_WIDTH{reset_n_i}};

   // active serial peripheral owns the shared pin
   always_comb begin
      for (int i = 0; i < PORT_D_WIDTH; i++) begin
         if (serial_pin_enable_i[i]) begin
            port_d_pin_o[i]    = serial_pin_data_i[i] & serial_oe_gated[i];
            port_d_pin_oe_o[i] = serial_oe_gated[i];
            read_d[i]          = port_d_pin_i[i];
         end else begin
            port_d_pin_o[i]    = bank_d_pin_o[i];
            port_d_pin_oe_o[i] = bank_d_pin_oe[i];
            read_d[i]          = read_d_bank[i];
         end
      end
   end

   // pullup on enabled port B inputs
   assign irq_enabled     = r.option & ~r.dir_b;
   assign port_b_pullup_o = irq_enabled;

   // enabled pins are wire-ANDed into one active-low line
   assign irq_line = &(port_b_pin_i | ~irq_enabled);

   // level term only when the external pin is edge-and-level
   assign irq_level_active = irq_edge_and_level_i & ~irq_line;

   assign port_b_irq_request_o = r.irq_edge | irq_level_active;

   always_comb begin
      next_r     = r;
      next_r.ack = access;

      // falling edge of the combined line
      next_r.irq_line_prev = irq_line;
      next_r.irq_edge      = r.irq_line_prev & ~irq_line;

      if (access && !wb_req_i.we) begin
         case (reg_idx)
            // data reads return pins or latches
            IDX_PORT_A_DATA:      next_r.rdata = {24'h000000, read_a};
            IDX_PORT_B_DATA:      next_r.rdata = {24'h000000, read_b};
            IDX_PORT_C_DATA:      next_r.rdata = {24'h000000, read_c};
            IDX_PORT_D_DATA:      next_r.rdata = {25'h0000000, read_d};
            IDX_PORT_A_DIRECTION: next_r.rdata = {24'h000000, r.dir_a};
            IDX_PORT_B_DIRECTION: next_r.rdata = {24'h000000, r.dir_b};
            IDX_PORT_C_DIRECTION: next_r.rdata = {24'h000000, r.dir_c};
            IDX_PORT_D_DIRECTION: next_r.rdata = {25'h0000000, r.dir_d};
            IDX_CONFIGURATION:    next_r.rdata = {31'h00000000, r.full_feature};
            IDX_PORT_B_OPTION:    next_r.rdata = {24'h000000, r.option};
            default:              next_r.rdata = READ_ZERO;
         endcase
      end else if (access) begin
         next_r.rdata = READ_ZERO;
      end

      // Only byte lane 0 carries register bits; other lanes are ignored
      if (wr_lane0) begin
         case (reg_idx)
            IDX_PORT_A_DATA:      next_r.data_a = wb_req_i.dat[7:0];
            IDX_PORT_B_DATA:      next_r.data_b = wb_req_i.dat[7:0];
            IDX_PORT_C_DATA:      next_r.data_c = wb_req_i.dat[7:0];
            IDX_PORT_D_DATA:      next_r.data_d = wb_req_i.dat[6:0];
            IDX_PORT_A_DIRECTION: next_r.dir_a  = wb_req_i.dat[7:0];
            IDX_PORT_B_DIRECTION: next_r.dir_b  = wb_req_i.dat[7:0];
            IDX_PORT_C_DIRECTION: next_r.dir_c  = wb_req_i.dat[7:0];
            IDX_PORT_D_DIRECTION: next_r.dir_d  = wb_req_i.dat[6:0];
            // Option and configuration are straps; writes are dropped
            default:              next_r.rdata  = next_r.rdata;
         endcase
      end

      if (!reset_n_i) begin
         next_r.ack           = 1'b0;
         next_r.rdata         = READ_ZERO;
         next_r.dir_a         = DIRECTION_RESET;
         next_r.dir_b         = DIRECTION_RESET;
         next_r.dir_c         = DIRECTION_RESET;
         next_r.dir_d         = DIRECTION_D_RESET;
         next_r.data_a        = r.data_a;
         next_r.data_b        = r.data_b;
         next_r.data_c        = r.data_c;
         next_r.data_d        = r.data_d;
         // Straps are sampled for as long as reset is held
         next_r.option        = port_b_option_register_i;
         next_r.full_feature  = full_feature_configuration_i;
         // Follow the real line so a pin held low through reset is no edge
         next_r.irq_line_prev = irq_line;
         next_r.irq_edge      = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      r <= next_r;
   end

   assign wb_rsp_o.ack = r.ack;
   assign wb_rsp_o.dat = r.rdata;

endmodule // parallel_io_ports

/* parallel_io_pkg.sv */
// Constants and carrier types for the parallel I/O port block
// Summary of operation
// - 31 pins: one 7-bit, three 8-bit ports
// - Port A data index 0, direction 4
// - Reset clears directions, keeps data registers
// - Direction 1 drives pin from data
// - Port B data index 1, direction 5
// - Option bits enable port B interrupt sources
// - Option plus input turns pullup on
// - Port B follows external pin sensitivity
// - Port C data 2, direction 6, strong top
// - Port D bidirectional or input-only by configuration
// - Port D direction works only full-feature
// - Serial peripherals override shared port D pins
// - Reset makes all port D pins inputs
package parallel_io_pkg;

   localparam int unsigned PORT_WIDTH     = 8;
   localparam int unsigned PORT_D_WIDTH   = 7;
   localparam int unsigned WB_ADDR_WIDTH  = 16;
   localparam int unsigned WB_DATA_WIDTH  = 32;
   localparam int unsigned REG_IDX_WIDTH  = 14;

   // Register indices; byte address is four times the index
   localparam logic [13:0] IDX_PORT_A_DATA      = 14'h0000;
   localparam logic [13:0] IDX_PORT_B_DATA      = 14'h0001;
   localparam logic [13:0] IDX_PORT_C_DATA      = 14'h0002;
   localparam logic [13:0] IDX_PORT_D_DATA      = 14'h0003;
   localparam logic [13:0] IDX_PORT_A_DIRECTION = 14'h0004;
   localparam logic [13:0] IDX_PORT_B_DIRECTION = 14'h0005;
   localparam logic [13:0] IDX_PORT_C_DIRECTION = 14'h0006;
   localparam logic [13:0] IDX_PORT_D_DIRECTION = 14'h0007;
   localparam logic [13:0] IDX_CONFIGURATION    = 14'h0008;
   localparam logic [13:0] IDX_PORT_B_OPTION    = 14'h3ff0;

   localparam logic [7:0]  DIRECTION_RESET   = 8'h00;
   localparam logic [6:0]  DIRECTION_D_RESET = 7'h00;
   localparam logic [31:0] READ_ZERO         = 32'h00000000;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [15:0] adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } wb_req_s;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } wb_rsp_s;

   typedef struct packed {
      logic        ack;
      logic [31:0] rdata;
      logic [7:0]  data_a;
      logic [7:0]  data_b;
      logic [7:0]  data_c;
      logic [6:0]  data_d;
      logic [7:0]  dir_a;
      logic [7:0]  dir_b;
      logic [7:0]  dir_c;
      logic [6:0]  dir_d;
      logic [7:0]  option;
      logic        full_feature;
      logic        irq_line_prev;
      logic        irq_edge;
   } io_state_s;

endpackage

/* port_bank.sv */
// One parallel port: per-pin direction, output drive and read-back
`timescale 1ns/1ps
module port_bank #(
   parameter int unsigned WIDTH = 8
) (
   input  wire logic [WIDTH-1:0] data_i,
   input  wire logic [WIDTH-1:0] dir_i,
   input  wire logic [WIDTH-1:0] pin_i,
   output logic      [WIDTH-1:0] pin_o,
   output logic      [WIDTH-1:0] pin_oe_o,
   output logic      [WIDTH-1:0] read_o
);

   genvar bit_idx;

   generate
      for (bit_idx = 0; bit_idx < WIDTH; bit_idx = bit_idx + 1) begin : g_pin
         // output follows latch
         // Masked so an uninitialised latch never reaches an input pin
         assign pin_o[bit_idx]    = dir_i[bit_idx] & data_i[bit_idx];
         assign pin_oe_o[bit_idx] = dir_i[bit_idx];
         assign read_o[bit_idx]   = dir_i[bit_idx] ? data_i[bit_idx] : pin_i[bit_idx];
      end
   endgenerate

endmodule // port_bank

/* parallel_io_ports_monitor.sv */
// Port-level assertions for the parallel I/O port block
`timescale 1ns/1ps
module parallel_io_ports_monitor (
   input  wire logic                sys_clk_i,
   input  wire logic                reset_n_i,
   input  parallel_io_pkg::wb_req_s wb_req_i,
   input  parallel_io_pkg::wb_rsp_s wb_rsp_o,
   input  wire logic [7:0]          port_a_pin_oe_o,
   input  wire logic [7:0]          port_b_pin_i,
   input  wire logic [7:0]          port_b_pin_oe_o,
   input  wire logic [7:0]          port_b_pullup_o,
   input  wire logic [6:0]          port_d_pin_oe_o,
   input  wire logic [6:0]          serial_pin_enable_i,
   input  wire logic [6:0]          serial_pin_oe_i,
   input  wire logic                irq_edge_and_level_i,
   input  wire logic                full_feature_configuration_i,
   input  wire logic                port_b_irq_request_o
);
   import parallel_io_pkg::*;
   // Only pins with pullup on can pull the request line low
   wire logic line = &(port_b_pin_i | ~port_b_pullup_o);
   wire logic take = wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   sequence line_fall;
      line ##1 !line;
   endsequence
   sequence dir_a_write;
      take && wb_req_i.we && wb_req_i.sel[0] && wb_req_i.adr[15:2] == IDX_PORT_A_DIRECTION;
   endsequence
   AST_ACK_NEXT: assert property (take |=> wb_rsp_o.ack)
      else $error("ack not one cycle after request");
   AST_ACK_PULSE: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
      else $error("ack longer than one cycle");
   AST_DIR_A: assert property (dir_a_write |=> port_a_pin_oe_o == $past(wb_req_i.dat[7:0]))
      else $error("port a enables differ from written direction");
   AST_RESET_OE: assert property (disable iff (1'b0) !reset_n_i |=>
      {port_a_pin_oe_o, port_b_pin_oe_o, port_d_pin_oe_o} == 23'h000000)
      else $error("pin driven after reset");
   AST_RESET_SERIAL: assert property (disable iff (1'b0) !reset_n_i |->
      (port_d_pin_oe_o & serial_pin_enable_i) == 7'h00) else $error("serial drive in reset");
   AST_PULLUP_IN: assert property ((port_b_pullup_o & port_b_pin_oe_o) == 8'h00)
      else $error("pullup on a driven pin");
   AST_COMPAT_D: assert property (!full_feature_configuration_i |->
      (port_d_pin_oe_o & ~serial_pin_enable_i) == 7'h00) else $error("port d drives");
   AST_SERIAL_OVR: assert property (((port_d_pin_oe_o ^ serial_pin_oe_i)
      & serial_pin_enable_i) == 7'h00) else $error("serial enable not followed");
   AST_IRQ_EDGE: assert property (line_fall |-> ##[0:2] port_b_irq_request_o)
      else $error("no request after line fall");
   AST_IRQ_LEVEL: assert property (irq_edge_and_level_i && !line |-> port_b_irq_request_o)
      else $error("no level request");
   AST_IRQ_QUIET_HI: assert property (line [*4] ##0 !irq_edge_and_level_i
      |-> !port_b_irq_request_o) else $error("request with line high");
   AST_IRQ_QUIET_LO: assert property (!line [*4] ##0 !irq_edge_and_level_i
      |-> !port_b_irq_request_o) else $error("edge request too long");
endmodule // parallel_io_ports_monitor
bind parallel_io_ports parallel_io_ports_monitor i_mon (
   .sys_clk_i                    (sys_clk_i),
   .reset_n_i                    (reset_n_i),
   .wb_req_i                     (wb_req_i),
   .wb_rsp_o                     (wb_rsp_o),
   .port_a_pin_oe_o              (port_a_pin_oe_o),
   .port_b_pin_i                 (port_b_pin_i),
   .port_b_pin_oe_o              (port_b_pin_oe_o),
   .port_b_pullup_o              (port_b_pullup_o),
   .port_d_pin_oe_o              (port_d_pin_oe_o),
   .serial_pin_enable_i          (serial_pin_enable_i),
   .serial_pin_oe_i              (serial_pin_oe_i),
   .irq_edge_and_level_i         (irq_edge_and_level_i),
   .full_feature_configuration_i (full_feature_configuration_i),
   .port_b_irq_request_o         (port_b_irq_request_o)
);

/* pin_board_model.sv */
// Board side of the pins: external drivers, pullups and floating lines
`timescale 1ns/1ps
module pin_board_model #(
   parameter int unsigned W = 31
) (
   input  wire logic         clk_i,
   input  wire logic [W-1:0] dut_o_i,
   input  wire logic [W-1:0] dut_oe_i,
   input  wire logic [W-1:0] pullup_i,
   input  wire logic [W-1:0] ext_i,
   input  wire logic [W-1:0] ext_oe_i,
   output logic      [W-1:0] pin_o
);
   logic [W-1:0] last = '0;
   always_comb pin_o = (dut_oe_i & dut_o_i) | (~dut_oe_i & ext_oe_i & ext_i)
      | (~dut_oe_i & ~ext_oe_i & (pullup_i | ~last));
   // Undriven lines without a pullup wander so a stale level is never trusted
   always_ff @(posedge clk_i) last <= pin_o;
endmodule // pin_board_model

/* parallel_io_ports_tb_top.sv */
// Self-checking testbench for the parallel I/O port block
`timescale 1ns/1ps
module parallel_io_ports_tb_top;
   import parallel_io_pkg::*;
   logic        sys_clk_i = 1'b0, reset_n_i = 1'b0, port_b_irq_request_o;
   wb_req_s     wb_req_i = '0;
   wb_rsp_s     wb_rsp_o;
   logic [7:0]  port_a_pin_o, port_a_pin_oe_o, port_b_pin_o, port_b_pin_oe_o;
   logic [7:0]  port_b_pullup_o, port_c_pin_o, port_c_pin_oe_o;
   logic [6:0]  port_d_pin_o, port_d_pin_oe_o;
   logic [6:0]  serial_pin_enable_i = '0, serial_pin_data_i = '0, serial_pin_oe_i = '0;
   logic        irq_edge_and_level_i = 1'b0, full_feature_configuration_i = 1'b1;
   logic [7:0]  port_b_option_register_i = 8'hf0;
   logic [30:0] ext = {7'h3c, 24'h3c3c3c}, ext_oe = '1, pins;
   wire logic [7:0]  port_a_pin_i = pins[7:0], port_b_pin_i = pins[15:8];
   wire logic [7:0]  port_c_pin_i = pins[23:16];
   wire logic [6:0]  port_d_pin_i = pins[30:24];
   wire logic [23:0] pin3 = {port_c_pin_o, port_b_pin_o, port_a_pin_o};
   wire logic [23:0] oe3 = {port_c_pin_oe_o, port_b_pin_oe_o, port_a_pin_oe_o};
   int          fail_count = 0, compares = 0;
   parallel_io_ports i_dut (.*);
   pin_board_model #(.W(31)) i_board (.clk_i(sys_clk_i), .ext_i(ext), .ext_oe_i(ext_oe),
      .dut_o_i({port_d_pin_o, pin3}), .dut_oe_i({port_d_pin_oe_o, oe3}),
      .pullup_i({15'h0000, port_b_pullup_o, 8'h00}), .pin_o(pins));
   always #5 sys_clk_i = ~sys_clk_i;
   task automatic summarize;
      if (fail_count == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Classic cycle: hold until ack is sampled, then one idle cycle follows
   task automatic wb(input logic we, input logic [15:0] a, input logic [7:0] d,
                     output logic [31:0] q);
      int n = 0;
      @(posedge sys_clk_i);
      wb_req_i <= '{1'b1, 1'b1, we, a, 4'h1, {24'h000000, d}};
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (wb_rsp_o.ack !== 1'b1 && n < 50);
      if (n < 50) begin
         q = wb_rsp_o.dat;
         wb_req_i <= '0;
      end else begin
         fail_count++;
         summarize();
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] exp, input string nm);
      logic [31:0] q;
      wb(1'b0, a, 8'h00, q);
      chk(nm, q, exp);
   endtask
   task automatic cnt(output int k);
      k = 0;
      repeat (6) begin
         @(posedge sys_clk_i);
         #1;
         k += int'(port_b_irq_request_o === 1'b1);
      end
   endtask
   task automatic rst(input logic f);
      reset_n_i <= 1'b0;
      full_feature_configuration_i <= f;
      repeat (11) @(posedge sys_clk_i);
      #1;
      chk("rst_d_oe", port_d_pin_oe_o, 32'h0);
      @(posedge sys_clk_i);
      reset_n_i <= 1'b1;
      serial_pin_enable_i <= 7'h00;
   endtask
   task automatic t_reset;
      int k;
      cnt(k);
      chk("rst_irq", 32'(k), 32'h0);
      for (int p = 0; p < 4; p++) rd(16'h0010 + 16'(p * 4), 32'h0, "dir");
   endtask
   task automatic t_ports;
      for (int p = 0; p < 3; p++) begin
         wr(16'(p * 4), 8'ha5);
         wr(16'h0010 + 16'(p * 4), 8'h0f);
         #1;
         chk("pin_o", pin3[p*8+:8], 8'h05);
         chk("pin_oe", oe3[p*8+:8], 8'h0f);
         rd(16'(p * 4), 32'h35, "data");
      end
      rd(16'hffc0, 32'hf0, "option");
      wr(16'hffc0, 8'h00);
      rd(16'hffc0, 32'hf0, "option");
      rd(16'h0040, 32'h0, "unmapped");
   endtask
   task automatic t_irq;
      int k;
      wr(16'h0004, 8'hff);
      wr(16'h0014, 8'h00);
      @(posedge sys_clk_i);
      ext[15:8] <= 8'hff;
      ext_oe[15:12] <= 4'h0;
      #1;
      chk("pullup", port_b_pullup_o, 8'hf0);
      rd(16'h0004, 32'hff, "data_b");
      @(posedge sys_clk_i);
      ext_oe[12] <= 1'b1;
      ext[12] <= 1'b0;
      cnt(k);
      chk("edge", 32'(k), 32'h1);
      @(posedge sys_clk_i);
      irq_edge_and_level_i <= 1'b1;
      cnt(k);
      chk("level", 32'(k), 32'h6);
      @(posedge sys_clk_i);
      irq_edge_and_level_i <= 1'b0;
      ext[12] <= 1'b1;
      ext[8] <= 1'b0;
      cnt(k);
      chk("masked", 32'(k), 32'h0);
   endtask
   task automatic t_portd;
      wr(16'h000c, 8'h55);
      wr(16'h001c, 8'h7f);
      #1;
      chk("d_o", port_d_pin_o, 7'h55);
      chk("d_oe", port_d_pin_oe_o, 7'h7f);
      @(posedge sys_clk_i);
      serial_pin_enable_i <= 7'h03;
      serial_pin_oe_i <= 7'h02;
      serial_pin_data_i <= 7'h02;
      #1;
      chk("d_o", port_d_pin_o, 7'h56);
      chk("d_oe", port_d_pin_oe_o, 7'h7e);
      rd(16'h000c, 32'h56, "data_d");
   endtask
   task automatic t_compat;
      rst(1'b0);
      rd(16'h0010, 32'h0, "dir_a");
      wr(16'h0010, 8'hff);
      #1;
      chk("a_o", port_a_pin_o, 8'ha5);
      wr(16'h001c, 8'h7f);
      #1;
      chk("d_oe", port_d_pin_oe_o, 7'h00);
      rd(16'h001c, 32'h7f, "dir_d");
      rd(16'h000c, 32'h3c, "data_d");
      rd(16'h0020, 32'h0, "config");
   endtask
   initial begin
      rst(1'b1);
      t_reset();
      t_ports();
      t_irq();
      t_portd();
      t_compat();
      summarize();
   end
endmodule // parallel_io_ports_tb_top
